// >>> hw/uart_fc_pkg.sv
// Constants and carrier types for the UART flow-control block.
// Assumes one 20 MHz APB clock shared by receiver and transmitter.
package uart_fc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [2:0] IDX_DATA = 3'h0;  // Rx holding / tx holding
   localparam logic [2:0] IDX_IER  = 3'h1;  // Interrupt enable
   localparam logic [2:0] IDX_ISR  = 3'h2;  // Status / FIFO ctrl / feature
   localparam logic [2:0] IDX_LCR  = 3'h3;  // Line control
   localparam logic [2:0] IDX_MCR  = 3'h4;  // Modem ctrl / resume char 1
   localparam logic [2:0] IDX_LSR  = 3'h5;  // Line status / resume char 2
   // Indices 6 and 7 hold pause chars 1 and 2 in the enhanced bank
   localparam logic [7:0] LCR_ENH  = 8'hbf;  // Opens enhanced bank
   // Reset values
   localparam logic [7:0] IER_RST  = 8'h02;  // Tx interrupt enabled
   localparam logic [7:0] ZERO_RST = 8'h00;
   // Field positions
   localparam int EFR_SPECIAL = 5;
   localparam int EFR_ARTS    = 6;
   localparam int EFR_ACTS    = 7;
   localparam int IER_RX      = 0;
   localparam int IER_THR     = 1;
   localparam int IER_PAUSE   = 5;
   localparam int IER_RTS     = 6;
   localparam int IER_CTS     = 7;
   localparam int MCR_RTS     = 1;
   localparam int MCR_IRQEN   = 3;
   localparam int MCR_ANYRES  = 5;
   // Interrupt status codes, highest priority first, except time-out outranks rx ready
   localparam logic [5:0] ISR_RXRDY = 6'h04;
   localparam logic [5:0] ISR_RXTO  = 6'h0c;
   localparam logic [5:0] ISR_THRE  = 6'h02;
   localparam logic [5:0] ISR_PAUSE = 6'h10;
   localparam logic [5:0] ISR_HWFC  = 6'h20;
   localparam logic [5:0] ISR_NONE  = 6'h01;
   // Receive trigger table, indexed by the FIFO ctrl trigger field
   localparam logic [6:0] RX_TRIG [4] = '{7'd8, 7'd16, 7'd56, 7'd60};
   localparam logic [6:0] RX_HI   [4] = '{7'd16, 7'd56, 7'd60, 7'd60};
   localparam logic [6:0] RX_LO   [4] = '{7'd0, 7'd8, 7'd16, 7'd56};
   // Time-out: four characters of ten bit times each
   localparam logic [5:0] TIMEOUT_BITS = 6'd40;
   // Character carrier
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } char_type;
   // Flow-control sender states
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_FIRST  = 2'b01,
      ST_SECOND = 2'b10
   } fc_state_type;
endpackage : uart_fc_pkg

// >>> hw/uart_flow_ctrl.sv
// One UART channel's flow control, receive FIFO and interrupt logic.
// Assumes a receiver and transmitter on pclk; pins pass two flip-flops.
`timescale 1ns/1ps
`default_nettype none
//
// Function
// R1: Feature bits 6/7 enable auto RTS/CTS
// R2: CTS rise flags status bit5, halts after char
// R3: CTS low again resumes transmission
// R4: Interrupt at trigger, RTS off at next level
// R5: RTS back on at level below trigger
// R6: Receiver keeps filling FIFO until full
// R7: Pause chars matched, transmit halts after char
// R8: Pause match sets flag, raises interrupt
// R9: Resume match restarts transmit, clears flag
// R10: Modem bit5 lets any character resume
// R11: Reset clears four character registers
// R12: Consumed flow characters never enter FIFO
// R13: Auto-send pause above, resume below level
// R14: Special char vs pause 2, stored, flagged
// R15: Software disables flow control in special mode
// R16: Compare only word-length bits, LSB aligned
// R17: Interrupt enable bits 5-7 gate flow interrupts
// R18: Reset leaves tx-empty interrupt pending, enabled
// R19: Status shows one source; CTS/RTS lowest
// R20: Rx ready and time-out share enable bit0
// R21: Time-out four chars, never empty, restartable
// R22: Select pin or modem bit3 enables irq
// R23: Enhanced registers only when line ctrl BFh
module uart_flow_ctrl
   import uart_fc_pkg::*;
#(
   parameter int DEPTH = 64                        // Receive FIFO depth
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output var  logic [31:0]         prdata,
   output var  logic                pready,
   output var  logic                pslverr,
   input  wire uart_fc_pkg::char_type rx_in,         // Received character
   input  wire logic                rx_stop_center,   // Centre of stop bit
   input  wire logic                bit_tick,         // One per bit time
   input  wire logic                tx_busy,          // Char being shifted
   output var  uart_fc_pkg::char_type tx_data,       // Holding reg to tx
   input  wire logic                tx_data_taken,
   output var  uart_fc_pkg::char_type fc_out,        // Pause/resume to send
   input  wire logic                fc_taken,
   output var  logic                tx_allow,         // Start next char
   input  wire logic                cts_pin,
   output var  logic                rts_pin,
   input  wire logic                irq_tristate_select_pin,
   output var  logic                irq_out_chan_a,
   output var  logic                irq_oe_n
);
   import uart_fc_pkg::*;

   // Word-length masked compare
   function automatic logic ch_eq(input logic [7:0] a, input logic [7:0] b,
                                  input logic [1:0] wl);
      logic [7:0] m;
      m = 8'hff >> (2'd3 - wl);
      return (a & m) == (b & m);
   endfunction : ch_eq

   logic [7:0]  lcr_q, ier_q, mcr_q, efr_q, fcr_q;  // Control registers
   logic [7:0]  chr_q [4];                          // Resume1/2, pause1/2
   logic        cts_m_q, cts_s_q, cts_p_q;          // CTS sync and history
   logic        sel_m_q, sel_s_q;                   // Select pin sync
   logic [7:0]  mem [DEPTH];                        // Receive FIFO storage
   logic [5:0]  wp_q, rp_q;                         // FIFO pointers
   logic [6:0]  cnt_q;                              // FIFO fill
   logic        ovr_q;                              // Overrun
   logic [7:0]  held_q, spill_q;                    // Double-mode parking
   logic        held_v_q, held_kind_q, spill_v_q;
   logic        pause_q;                            // Tx suspended by pause
   logic        pflag_q, hwflag_q, thre_q;          // Pending sources
   logic [5:0]  to_cnt_q;                           // Time-out bit counter
   logic        to_q;                               // Time-out pending
   logic        xsent_q, kind_q;                    // Auto-send state
   fc_state_type st_q;

   // Bus decode
   wire       setup  = psel & ~penable;
   wire       acc    = psel & penable & pready;
   wire       wr     = acc & pwrite;
   wire       rd     = acc & ~pwrite;
   wire [2:0] idx    = paddr[4:2];
   wire       mapped = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
   wire       enh    = lcr_q == LCR_ENH;            // R23
   wire       gen    = ~lcr_q[7];                   // General bank
   wire       pop    = rd & gen & (idx == IDX_DATA) & (cnt_q != 7'd0);
   wire       isr_rd = rd & gen & (idx == IDX_ISR);
   wire       lsr_rd = rd & gen & (idx == IDX_LSR);
   wire       thr_wr = wr & gen & (idx == IDX_DATA);

   // Receive compare; modes from feature bits 1:0
   wire [1:0] wl     = lcr_q[1:0];                  // R16
   wire [7:0] rxc    = rx_in.data;
   wire       v      = rx_in.valid;
   wire       single = efr_q[1] ^ efr_q[0];
   wire       dbl    = efr_q[1] & efr_q[0];
   wire       p_one  = ch_eq(rxc, efr_q[1] ? chr_q[2] : chr_q[3], wl);
   wire       r_one  = ch_eq(rxc, efr_q[1] ? chr_q[0] : chr_q[1], wl);
   wire       f_p    = ch_eq(rxc, chr_q[2], wl);
   wire       f_r    = ch_eq(rxc, chr_q[0], wl);
   wire       sec_ok = ch_eq(rxc, held_kind_q ? chr_q[1] : chr_q[3], wl);
   wire       dbl_ok = v & dbl & held_v_q & sec_ok;
   wire       p_hit  = v & single & p_one | dbl_ok & ~held_kind_q;  // R7
   wire       r_hit  = v & single & r_one & ~p_one | dbl_ok & held_kind_q;
   wire       h_new  = v & dbl & ~held_v_q & (f_p | f_r);
   wire       consume = p_hit | r_hit | h_new;               // R12
   wire       push_h = v & dbl & held_v_q & ~sec_ok;
   wire       push_c = v & ~consume & ~push_h;
   wire       any_r  = v & mcr_q[MCR_ANYRES] & pause_q & ~p_hit;  // R10
   wire       resume = r_hit | any_r;                        // R9
   wire       special = v & efr_q[EFR_SPECIAL] & ch_eq(rxc, chr_q[3], wl);
   wire       push   = push_h | push_c | spill_v_q;
   wire [7:0] pdata  = push_h ? held_q : (spill_v_q ? spill_q : rxc);
   wire       full   = cnt_q == 7'(DEPTH);

   // Trigger levels
   wire [6:0] trig   = RX_TRIG[fcr_q[7:6]];
   wire [6:0] hi     = RX_HI[fcr_q[7:6]];
   wire [6:0] lo     = RX_LO[fcr_q[7:6]];
   wire       at_hi  = cnt_q >= hi;
   wire       at_lo  = cnt_q <= lo;

   // Hardware flow
   wire       cts_rise = cts_s_q & ~cts_p_q;
   wire       rts_d    = efr_q[EFR_ARTS] ? (at_hi | (rts_pin & ~at_lo))
                                         : ~mcr_q[MCR_RTS];
   wire       rts_rise = efr_q[EFR_ARTS] & rts_d & ~rts_pin;
   wire       halt     = efr_q[EFR_ACTS] & cts_s_q | pause_q;

   // Interrupt priority encoder
   wire       rx_src  = ier_q[IER_RX] & ((cnt_q >= trig) | to_q);     // R20
   wire       thr_src = ier_q[IER_THR] & thre_q;
   wire [5:0] int_status_reg     = rx_src  ? (to_q ? ISR_RXTO : ISR_RXRDY) :
                        thr_src ? ISR_THRE :
                        pflag_q ? ISR_PAUSE :
                        hwflag_q ? ISR_HWFC : ISR_NONE;              // R19
   wire [7:0] line_status_reg     = {1'b0, ~tx_data.valid & ~tx_busy, ~tx_data.valid,
                         3'h0, ovr_q, cnt_q != 7'd0};

   // Read mux
   wire [7:0] rd_byte = !mapped ? 8'h00 :
                        enh && idx == IDX_ISR ? efr_q :
                        enh && idx[2] ? chr_q[idx[1:0]] :
                        !gen && idx != IDX_LCR ? 8'h00 :
                        idx == IDX_DATA ? mem[rp_q] :
                        idx == IDX_IER ? ier_q :
                        idx == IDX_ISR ? {fcr_q[0], fcr_q[0], int_status_reg} :
                        idx == IDX_LCR ? lcr_q :
                        idx == IDX_MCR ? mcr_q :
                        idx == IDX_LSR ? line_status_reg : 8'h00;

   // APB answer: one wait-free access phase after setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~mapped;
         if (setup) begin
            prdata <= {24'h0, rd_byte};
         end
      end
   end

   // Control registers; enhanced ones only in the BFh bank
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lcr_q <= ZERO_RST;
         ier_q <= IER_RST;                                  // R18
         mcr_q <= ZERO_RST;                                 // R10
         efr_q <= ZERO_RST;
         fcr_q <= ZERO_RST;
      end else if (wr && mapped) begin
         if (idx == IDX_LCR) lcr_q <= pwdata[7:0];
         if (gen && idx == IDX_IER) ier_q <= pwdata[7:0];   // R17
         if (gen && idx == IDX_MCR) mcr_q <= pwdata[7:0];
         if (gen && idx == IDX_ISR) fcr_q <= pwdata[7:0];
         if (enh && idx == IDX_ISR) efr_q <= pwdata[7:0];   // R1 R23
      end
   end

   // Four character registers, cleared by reset
   for (genvar i = 0; i < 4; i++) begin : g_chr
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            chr_q[i] <= ZERO_RST;                           // R11
         end else if (wr && mapped && enh && idx[2] && idx[1:0] == 2'(i)) begin
            chr_q[i] <= pwdata[7:0];                        // R23
         end
      end
   end

   // Pin synchronisers; first stage read only by the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cts_m_q <= 1'b0;
         cts_s_q <= 1'b0;
         cts_p_q <= 1'b0;
         sel_m_q <= 1'b0;
         sel_s_q <= 1'b0;
      end else begin
         cts_m_q <= cts_pin;
         cts_s_q <= cts_m_q;
         cts_p_q <= cts_s_q;
         sel_m_q <= irq_tristate_select_pin;
         sel_s_q <= sel_m_q;
      end
   end

   // FIFO write side; accepts while not full regardless of RTS
   always_ff @(posedge pclk) begin
      if (push && !full) begin
         mem[wp_q] <= pdata;                                // R6
      end
   end

   // FIFO pointers, fill and overrun
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp_q  <= 6'h0;
         rp_q  <= 6'h0;
         cnt_q <= 7'h0;
         ovr_q <= 1'b0;
      end else begin
         if (push && !full) wp_q <= wp_q + 6'h1;
         if (pop) rp_q <= rp_q + 6'h1;
         cnt_q <= cnt_q + 7'(push && !full) - 7'(pop);
         ovr_q <= (push & full) | (ovr_q & ~lsr_rd);
      end
   end

   // Double-mode parking of a first match; spill replays a mismatch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         held_q      <= 8'h0;
         held_v_q    <= 1'b0;
         held_kind_q <= 1'b0;
         spill_q     <= 8'h0;
         spill_v_q   <= 1'b0;
      end else begin
         held_v_q  <= h_new | (held_v_q & dbl & ~v);
         spill_v_q <= push_h;
         if (push_h) spill_q <= rxc;
         if (h_new) begin
            held_q      <= rxc;
            held_kind_q <= ~f_p;
         end
      end
   end

   // Pause state, flags; set beats clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pause_q  <= 1'b0;
         pflag_q  <= 1'b0;
         hwflag_q <= 1'b0;
         thre_q   <= 1'b1;                                  // R18
      end else begin
         pause_q  <= p_hit | (pause_q & ~resume);           // R7 R9 R10
         pflag_q  <= ((p_hit | special) & ier_q[IER_PAUSE]) // R8 R14
                     | (pflag_q & ~resume & ~(isr_rd && int_status_reg == ISR_PAUSE));
         hwflag_q <= (cts_rise & efr_q[EFR_ACTS] & ier_q[IER_CTS])  // R2
                     | (rts_rise & ier_q[IER_RTS])                  // R17
                     | (hwflag_q & ~(isr_rd && int_status_reg == ISR_HWFC));
         thre_q   <= (tx_data_taken & tx_data.valid)
                     | (thre_q & ~thr_wr & ~(isr_rd && int_status_reg == ISR_THRE));
      end
   end

   // Time-out counter in bit times, restarted by stop bit or read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         to_cnt_q <= 6'h0;
         to_q     <= 1'b0;
      end else if (rx_stop_center || pop || cnt_q == 7'd0) begin
         to_cnt_q <= 6'h0;                                  // R21
         to_q     <= 1'b0;
      end else if (bit_tick && !to_q) begin
         to_cnt_q <= to_cnt_q + 6'h1;
         to_q     <= to_cnt_q == TIMEOUT_BITS - 6'h1;       // R21
      end
   end

   // Holding register, transmit gate, RTS and interrupt pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_data  <= '0;
         tx_allow <= 1'b1;
         rts_pin  <= 1'b1;
         irq_out_chan_a <= 1'b0;
         irq_oe_n <= 1'b1;
      end else begin
         if (thr_wr) tx_data <= {1'b1, pwdata[7:0]};
         else if (tx_data_taken) tx_data.valid <= 1'b0;
         // Gates only the next start; a char in flight still finishes
         tx_allow <= ~halt;                                 // R2 R3 R7
         rts_pin  <= rts_d;                                 // R4 R5
         irq_out_chan_a <= int_status_reg != ISR_NONE;
         irq_oe_n <= ~(sel_s_q | mcr_q[MCR_IRQEN]);         // R22
      end
   end

   // Automatic pause/resume sender, one or two characters
   wire [1:0] txm  = efr_q[3:2];
   wire       need = (txm != 2'b00) & (xsent_q ? at_lo : at_hi);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q    <= ST_IDLE;
         fc_out  <= '0;
         xsent_q <= 1'b0;
         kind_q  <= 1'b0;
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (need) begin                              // R13
                  st_q    <= ST_FIRST;
                  kind_q  <= xsent_q;
                  xsent_q <= ~xsent_q;
                  fc_out  <= {1'b1, xsent_q ?
                             (txm == 2'b01 ? chr_q[1] : chr_q[0]) :
                             (txm == 2'b01 ? chr_q[3] : chr_q[2])};
               end
            end
            ST_FIRST: begin
               if (fc_taken && txm == 2'b11) begin
                  st_q   <= ST_SECOND;
                  fc_out <= {1'b1, kind_q ? chr_q[1] : chr_q[3]};
               end else if (fc_taken) begin
                  st_q   <= ST_IDLE;
                  fc_out <= '0;
               end
            end
            ST_SECOND: begin
               if (fc_taken) begin
                  st_q   <= ST_IDLE;
                  fc_out <= '0;
               end
            end
            default: begin
               st_q   <= ST_IDLE;
               fc_out <= '0;
            end
         endcase
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_cts_halt;
      $rose(cts_s_q) && efr_q[EFR_ACTS] && !tx_busy |=> !tx_allow;
   endproperty
   a_cts_halt: assert property (p_cts_halt) else $error("cts no halt"); // R2
   property p_cts_resume;
      efr_q[EFR_ACTS] && !cts_s_q && !pause_q && !tx_busy |=> tx_allow;
   endproperty
   a_cts_resume: assert property (p_cts_resume) else $error("no resume"); // R3
   property p_rts_hi;
      efr_q[EFR_ARTS] && at_hi |=> rts_pin;
   endproperty
   a_rts_hi: assert property (p_rts_hi) else $error("rts not off"); // R4
   property p_rts_lo;
      efr_q[EFR_ARTS] && at_lo && !at_hi |=> !rts_pin;
   endproperty
   a_rts_lo: assert property (p_rts_lo) else $error("rts not on"); // R5
   property p_no_stack;
      v && consume && !spill_v_q && !pop |=> cnt_q == $past(cnt_q);
   endproperty
   a_no_stack: assert property (p_no_stack) else $error("fc char kept"); // R12
   property p_pause;
      p_hit && ier_q[IER_PAUSE] |=> pflag_q && pause_q ##1 irq_out_chan_a;
   endproperty
   a_pause: assert property (p_pause) else $error("pause lost"); // R8
   property p_any;
      any_r && !special |=> !pause_q && !pflag_q;
   endproperty
   a_any: assert property (p_any) else $error("any no resume"); // R10
   property p_irq_oe;
      sel_s_q |=> !irq_oe_n;
   endproperty
   a_irq_oe: assert property (p_irq_oe) else $error("irq oe off"); // R22
   property p_special;
      special && !full && !consume && !spill_v_q && !pop && ier_q[IER_PAUSE]
         |=> pflag_q && cnt_q == $past(cnt_q) + 7'd1;
   endproperty
   a_special: assert property (p_special) else $error("special lost"); // R14

   c_pause: cover property (p_hit ##[1:200] resume);
   c_cts: cover property (efr_q[EFR_ACTS] && cts_rise);
   c_send: cover property (st_q == ST_SECOND && fc_taken);
endmodule : uart_flow_ctrl
`default_nettype wire

// >>> testbench/remote_uart_model.sv
// Far-side model: remote UART sending characters, driving CTS, taking tx chars.
// Assumes the device samples rx_in for a single pclk cycle per character.
`timescale 1ns/1ps
`default_nettype none
module remote_uart_model
   import uart_fc_pkg::*;
(
   input  wire logic                  pclk,
   input  wire logic                  cts_level,
   input  wire uart_fc_pkg::char_type tx_data,
   input  wire uart_fc_pkg::char_type fc_out,
   input  wire logic                  tx_allow,
   output var  uart_fc_pkg::char_type rx_in,
   output var  logic                  rx_stop_center,
   output var  logic                  tx_busy,
   output var  logic                  tx_data_taken,
   output var  logic                  fc_taken,
   output var  logic                  cts_pin
);
   int         busy_cnt = 0;  // Cycles left on the wire
   int         slow     = 0;  // Extra cycles, for a stalling far side
   logic [7:0] sent_q[$];     // Everything the device transmitted
   assign tx_busy = (busy_cnt != 0);
   assign cts_pin = cts_level;
   initial begin
      rx_in          = '0;
      rx_stop_center = 1'b0;
      tx_data_taken  = 1'b0;
      fc_taken       = 1'b0;
   end
   // One char at a time; flow chars jump ahead of data
   always @(posedge pclk) begin
      tx_data_taken <= 1'b0;
      fc_taken      <= 1'b0;
      if (busy_cnt != 0) begin
         busy_cnt <= busy_cnt - 1;
      end else if (fc_out.valid) begin
         fc_taken <= 1'b1;
         busy_cnt <= 10 + slow;
         sent_q.push_back(fc_out.data);
      end else if (tx_data.valid && tx_allow) begin
         tx_data_taken <= 1'b1;
         busy_cnt <= 10 + slow;
         sent_q.push_back(tx_data.data);
      end
   end
   // One received char, spaced so the next is legal at once
   task automatic send(input logic [7:0] d);
      @(posedge pclk);
      rx_in          <= '{1'b1, d};
      rx_stop_center <= 1'b1;
      @(posedge pclk);
      rx_in          <= '{1'b0, ~d};  // No stale value once released
      rx_stop_center <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask : send
endmodule : remote_uart_model
`default_nettype wire

// >>> testbench/uart_flow_ctrl_test.sv
// Self-checking bench for the UART flow-control block.
// Assumes remote_uart_model as far side and an APB master written here.
`timescale 1ns/1ps
`default_nettype none
module uart_flow_ctrl_test;
   import uart_fc_pkg::*;
   logic       pclk, presetn, psel, penable, pwrite, bit_tick, cts_level;
   logic       irq_tristate_select_pin, rerr;
   logic [7:0] paddr, d, v[4];
   logic [31:0] pwdata, prdata, rdata;
   logic       pready, pslverr, tx_busy, tx_data_taken, fc_taken, tx_allow;
   logic       cts_pin, rts_pin, irq_out_chan_a, irq_oe_n, rx_stop_center;
   char_type   rx_in, tx_data, fc_out;
   logic [7:0] exp_q[$];      // Expected receive FIFO contents
   int         error_cnt = 0;
   int         compares  = 0;
   int         i;
   uart_flow_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_in(rx_in), .rx_stop_center(rx_stop_center),
      .bit_tick(bit_tick), .tx_busy(tx_busy), .tx_data(tx_data),
      .tx_data_taken(tx_data_taken), .fc_out(fc_out), .fc_taken(fc_taken),
      .tx_allow(tx_allow), .cts_pin(cts_pin), .rts_pin(rts_pin),
      .irq_tristate_select_pin(irq_tristate_select_pin),
      .irq_out_chan_a(irq_out_chan_a), .irq_oe_n(irq_oe_n));
   remote_uart_model m (.pclk(pclk), .cts_level(cts_level), .tx_data(tx_data),
      .fc_out(fc_out), .tx_allow(tx_allow), .rx_in(rx_in), .rx_stop_center(rx_stop_center),
      .tx_busy(tx_busy), .tx_data_taken(tx_data_taken), .fc_taken(fc_taken),
      .cts_pin(cts_pin));
   // 50 ns clock
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   task automatic report_and_stop();
      $display("compares=%0d error_cnt=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // One APB transfer; waits for pready under a bound
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16 && pready !== 1'b1; n++) @(posedge pclk);
      if (n == 16) begin
         error_cnt++;
         report_and_stop();
      end
      rdata   = prdata;
      rerr    = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [7:0] wd);
      bus(1'b1, a, wd);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 8'h00);
      chk(rdata, e);
   endtask : rd
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge pclk);
         bit_tick <= 1'b1;
         @(posedge pclk);
         bit_tick <= 1'b0;
      end
   endtask : ticks
   // Reset held 12 cycles, expected queue emptied
   task automatic do_reset();
      presetn <= 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      exp_q.delete();
   endtask : do_reset
   initial begin
      {psel, penable, pwrite, bit_tick, cts_level, irq_tristate_select_pin} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      presetn = 1'b0;
      void'($urandom(87));
      do_reset();
      // Power-up state and unmapped access
      rd(8'h04, 32'h02);
      chk(irq_out_chan_a, 1'b1);
      rd(8'h08, 32'h02);
      rd(8'h08, 32'h01);
      rd(8'h20, 32'h0);
      chk(rerr, 1'b1);
      // Char regs: hidden outside the enhanced bank, zero after reset
      wr(8'h18, 8'haa);
      wr(8'h0c, 8'hbf);
      for (i = 0; i < 4; i++) begin
         rd(8'h10 + 8'(4 * i), 32'h0);
         v[i] = 8'($urandom);
         wr(8'h10 + 8'(4 * i), v[i]);
         rd(8'h10 + 8'(4 * i), {24'h0, v[i]});
      end
      wr(8'h08, 8'h02);
      wr(8'h18, 8'h13);
      wr(8'h10, 8'h11);
      wr(8'h0c, 8'h03);
      wr(8'h04, 8'h21);
      // Pause then resume, pause not stored
      m.send(8'h13);
      chk(tx_allow, 1'b0);
      chk(irq_out_chan_a, 1'b1);
      rd(8'h14, 32'h60);
      m.send(8'h11);
      chk(tx_allow, 1'b1);
      rd(8'h08, 32'h01);
      wr(8'h0c, 8'h00);
      m.send(8'hf3);
      chk(tx_allow, 1'b0);
      wr(8'h10, 8'h20);
      m.send(8'h41);
      chk(tx_allow, 1'b1);
      // Auto CTS, masked behind rx trigger
      do_reset();
      wr(8'h0c, 8'hbf);
      wr(8'h08, 8'hc0);
      wr(8'h0c, 8'h03);
      wr(8'h08, 8'h01);
      wr(8'h04, 8'h81);
      cts_level <= 1'b1;
      repeat (5) @(posedge pclk);
      chk(tx_allow, 1'b0);
      wr(8'h00, 8'h5c);
      for (i = 0; i < 8; i++) begin
         d = 8'($urandom);
         exp_q.push_back(d);
         m.send(d);
      end
      rd(8'h08, 32'hc4);
      for (i = 0; i < 8; i++) rd(8'h00, {24'h0, exp_q.pop_front()});
      rd(8'h08, 32'he0);
      chk(m.sent_q.size(), 0);
      cts_level <= 1'b0;
      repeat (5) @(posedge pclk);
      chk(tx_allow, 1'b1);
      chk(m.sent_q.pop_front(), 8'h5c);
      // Auto RTS and auto send, far side stalling
      do_reset();
      wr(8'h0c, 8'hbf);
      wr(8'h18, 8'h13);
      wr(8'h10, 8'h11);
      wr(8'h1c, 8'h93);
      wr(8'h14, 8'h91);
      wr(8'h08, 8'h4c);
      wr(8'h0c, 8'h03);
      wr(8'h08, 8'h01);
      wr(8'h10, 8'h02);
      wr(8'h04, 8'h41);
      m.slow = 20;
      m.sent_q.delete();
      for (i = 1; i <= 65; i++) begin
         d = 8'($urandom);
         if (i <= 64) exp_q.push_back(d);
         m.send(d);
         if (i == 7) chk(irq_out_chan_a, 1'b0);
         if (i == 8) chk(irq_out_chan_a, 1'b1);
         if (i == 15) chk(rts_pin, 1'b0);
         if (i == 16) chk(rts_pin, 1'b1);
      end
      rd(8'h14, 32'h63);
      for (i = 0; i < 64; i++) begin
         if (i == 63) chk(rts_pin, 1'b1);
         rd(8'h00, {24'h0, exp_q.pop_front()});
      end
      repeat (60) @(posedge pclk);
      chk(rts_pin, 1'b0);
      chk(m.sent_q.size(), 4);
      chk(m.sent_q[0], 8'h13);
      chk(m.sent_q[1], 8'h93);
      chk(m.sent_q[2], 8'h11);
      chk(m.sent_q[3], 8'h91);
      // Receive time-out
      do_reset();
      wr(8'h08, 8'h01);
      wr(8'h04, 8'h01);
      m.send(8'h5a);
      ticks(39);
      chk(irq_out_chan_a, 1'b0);
      ticks(1);
      repeat (2) @(posedge pclk);
      rd(8'h08, 32'hcc);
      rd(8'h00, 32'h5a);
      ticks(45);
      rd(8'h08, 32'hc1);
      // Interrupt pin enable
      irq_tristate_select_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(irq_oe_n, 1'b0);
      irq_tristate_select_pin <= 1'b0;
      wr(8'h10, 8'h08);
      repeat (4) @(posedge pclk);
      chk(irq_oe_n, 1'b0);
      wr(8'h10, 8'h00);
      repeat (2) @(posedge pclk);
      chk(irq_oe_n, 1'b1);
      // Special char kept in FIFO, flow bits off
      do_reset();
      wr(8'h0c, 8'hbf);
      wr(8'h1c, v[3]);
      wr(8'h08, 8'h20);
      wr(8'h0c, 8'h03);
      wr(8'h04, 8'h20);
      m.send(v[3]);
      rd(8'h08, 32'h10);
      rd(8'h00, {24'h0, v[3]});
      report_and_stop();
   end
endmodule : uart_flow_ctrl_test
`default_nettype wire
